// ===== core/fftio_defines.vh
// Constants shared by the FFT processor pin-level control block
`ifndef FFTIO_DEFINES_VH
`define FFTIO_DEFINES_VH

// ********************************************
// Mode word field positions
// ********************************************
`define FFTIO_MB_COMPLEX 0
`define FFTIO_MB_GROW3 1
`define FFTIO_MB_LFRAC_LO 2
`define FFTIO_MB_LFRAC_HI 3
`define FFTIO_MB_TRIGGER 4
`define FFTIO_MB_DAV_DLY 5
`define FFTIO_MB_TIED 6
`define FFTIO_MB_RATIO_LO 7
`define FFTIO_MB_RATIO_HI 8
`define FFTIO_MB_SIZE_LO 9
`define FFTIO_MB_SIZE_HI 10

// ********************************************
// Reset values and encodings
// ********************************************
`define FFTIO_MODE_RST 16'h0000
`define FFTIO_LFRAC_FULL 2'h0
`define FFTIO_LFRAC_QUARTER 2'h1
`define FFTIO_LFRAC_HALF 2'h2

// ********************************************
// Counts
// ********************************************
`define FFTIO_DAV_DELAY 5'h18
`define FFTIO_MAX_PASS_SHIFT 5'h04
`define FFTIO_MAX_SHIFT 4'hF
`define FFTIO_MAX_SHIFT_2BIT 4'hE
`define FFTIO_OVF_CODE 4'hF

`endif

// ===== core/fftio_top.v
// Pin-level load, dump, mode and scaling control of the FFT processor
//
// Functional notes
// - Auxiliary port carries imaginary or second real samples while config strobe high.
// - Rising edge of config strobe captures auxiliary port as mode word.
// - Control logic held in reset while config strobe is low.
// - Real result bus driven only while result valid and dump enable active.
// - Imaginary result bus driven only while result valid and dump enable active.
// - Shift count outputs show total normalising shifts of the transform.
// - With 2-place growth, shifts limited to 14 and 15 means overflow.
// - Load flag set by load enable, cleared after full, quarter or half block.
// - Load enable is either a low gate on input strobe or a trigger.
// - One sample accepted on each rising input strobe edge.
// - Dump advances one word on each rising output strobe edge.
// - Output strobe tied to input strobe: input edges internally scaled for output.
// - Result valid goes low on completion; results leave in natural order.
// - Optionally result valid delayed by 24 output strobes.
// - Dump starts on result valid if dump enable low, else waits for it.
// - Scaling disable high bypasses block floating normalisation.
// - Config strobe, load enable, result valid and dump enable are active low.
// - On overflow every output bin is forced to zero.
// - At most four shifts before each later pass, fifteen in total with 3-place growth.
`include "fftio_defines.vh"
`default_nettype none

module fftio_top #(
   parameter AW = 10,
   parameter DW = 16
) (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst,
   // Device pins
   input wire [DW-1:0] i_real_sample_in,
   input wire [DW-1:0] i_aux_port,
   input wire i_config_strobe_n,
   input wire i_load_enable_n,
   input wire i_input_strobe,
   input wire i_output_strobe,
   input wire i_dump_enable_n,
   input wire i_scaling_disable,
   output reg [DW-1:0] o_real_result_out,
   output reg o_real_result_oe_n,
   output reg [DW-1:0] o_imag_result_out,
   output reg o_imag_result_oe_n,
   output reg [3:0] o_shift_count,
   output reg o_load_flag,
   output reg o_result_valid_n,
   // Sample write port to workspace RAM
   output reg [DW-1:0] o_smp_real,
   output reg [DW-1:0] o_smp_imag,
   output reg [AW-1:0] o_smp_addr,
   output reg o_smp_we,
   // Butterfly engine handshake
   output reg [15:0] o_mode_word,
   output reg o_xform_start,
   output reg [2:0] o_pass_shift,
   input wire i_pass_done,
   input wire [4:0] i_pass_sign_bits,
   input wire i_pass_overflow,
   input wire i_xform_done,
   // Result read port of workspace RAM
   output reg [AW-1:0] o_res_addr,
   input wire [DW-1:0] i_res_real,
   input wire [DW-1:0] i_res_imag
);

   // ********************************************
   // Functions
   // ********************************************
   // Block length from the size field: 16, 64, 256 or 1024 points
   function [AW:0] fn_blk_len;
      input [1:0] size;
      begin
         fn_blk_len = {{AW{1'b0}}, 1'b1} << (5'h04 + {2'h0, size, 1'b0});
      end
   endfunction

   // ********************************************
   // Pin synchronisers
   // ********************************************
   reg [1:0] cfg_sy;
   reg [1:0] len_sy;
   reg [2:0] dis_sy;
   reg [2:0] dos_sy;
   reg [1:0] den_sy;
   reg [1:0] dsb_sy;
   reg [DW-1:0] d_sy1;
   reg [DW-1:0] d_sy2;
   reg [DW-1:0] aux_sy1;
   reg [DW-1:0] aux_sy2;
   reg cfg_prev;
   reg len_prev;

   // Edges are taken between the second and third stages only
   // Strobe stages reset to their idle levels so no false edge follows reset
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         cfg_sy <= 2'h3;
         len_sy <= 2'h3;
         dis_sy <= 3'h0;
         dos_sy <= 3'h0;
         den_sy <= 2'h3;
         dsb_sy <= 2'h0;
         d_sy1 <= {DW{1'b0}};
         d_sy2 <= {DW{1'b0}};
         aux_sy1 <= {DW{1'b0}};
         aux_sy2 <= {DW{1'b0}};
         cfg_prev <= 1'b1;
         len_prev <= 1'b1;
      end else begin
         cfg_sy <= {cfg_sy[0], i_config_strobe_n};
         len_sy <= {len_sy[0], i_load_enable_n};
         dis_sy <= {dis_sy[1:0], i_input_strobe};
         dos_sy <= {dos_sy[1:0], i_output_strobe};
         den_sy <= {den_sy[0], i_dump_enable_n};
         dsb_sy <= {dsb_sy[0], i_scaling_disable};
         d_sy1 <= i_real_sample_in;
         d_sy2 <= d_sy1;
         aux_sy1 <= i_aux_port;
         aux_sy2 <= aux_sy1;
         cfg_prev <= cfg_sy[1];
         len_prev <= len_sy[1];
      end
   end

   wire dis_rise = dis_sy[1] & ~dis_sy[2];
   wire dos_rise = dos_sy[1] & ~dos_sy[2];
   wire cfg_rise = cfg_sy[1] & ~cfg_prev;
   wire len_fall = ~len_sy[1] & len_prev;
   wire len_act = ~len_sy[1];
   wire den_act = ~den_sy[1];
   // Control logic is held in reset while the strobe is low
   wire ctl_rst = i_rst | ~cfg_sy[1];

   // ********************************************
   // Mode word capture
   // ********************************************
   // Aux is sampled through its own two stages, so the word must be
   // stable for a few clocks around the strobe's rising edge.
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_mode_word <= `FFTIO_MODE_RST;
      end else if (cfg_rise) begin
         o_mode_word <= aux_sy2;
      end
   end

   wire m_grow3 = o_mode_word[`FFTIO_MB_GROW3];
   wire [1:0] m_lfrac = o_mode_word[`FFTIO_MB_LFRAC_HI:`FFTIO_MB_LFRAC_LO];
   wire m_trigger = o_mode_word[`FFTIO_MB_TRIGGER];
   wire m_dav_dly = o_mode_word[`FFTIO_MB_DAV_DLY];
   wire m_tied = o_mode_word[`FFTIO_MB_TIED];
   wire [1:0] m_ratio = o_mode_word[`FFTIO_MB_RATIO_HI:`FFTIO_MB_RATIO_LO];
   wire [1:0] m_size = o_mode_word[`FFTIO_MB_SIZE_HI:`FFTIO_MB_SIZE_LO];
   wire [AW:0] blk_len = fn_blk_len(m_size);
   wire [2:0] n_pass = {1'b0, m_size} + 3'h2;

   // ********************************************
   // Sample loading
   // ********************************************
   reg loading;
   reg [AW:0] ld_cnt;
   reg blk_full;
   wire [AW:0] next_ld_cnt = ld_cnt + {{AW{1'b0}}, 1'b1};
   reg [AW:0] flag_end;

   always @* begin
      case (m_lfrac)
         `FFTIO_LFRAC_QUARTER: flag_end = blk_len >> 2;
         `FFTIO_LFRAC_HALF: flag_end = blk_len >> 1;
         default: flag_end = blk_len;
      endcase
   end

   // Gate mode: edges count while enable is low. Trigger mode: a falling
   // enable starts a block that then runs to its end on its own.
   wire take = dis_rise & (m_trigger ? loading : len_act);

   always @(posedge i_clk_sys) begin
      if (ctl_rst) begin
         loading <= 1'b0;
         ld_cnt <= {(AW+1){1'b0}};
         blk_full <= 1'b0;
         o_load_flag <= 1'b0;
         o_smp_we <= 1'b0;
         o_smp_addr <= {AW{1'b0}};
         o_smp_real <= {DW{1'b0}};
         o_smp_imag <= {DW{1'b0}};
      end else begin
         o_smp_we <= take;
         blk_full <= 1'b0;
         if (m_trigger ? len_fall : len_act) begin
            loading <= 1'b1;
            o_load_flag <= 1'b1;
         end
         if (take) begin
            o_smp_addr <= ld_cnt[AW-1:0];
            o_smp_real <= d_sy2;
            // Imaginary or second real stream, per mode
            o_smp_imag <= aux_sy2;
            if (next_ld_cnt == flag_end) begin
               o_load_flag <= 1'b0;
            end
            if (next_ld_cnt == blk_len) begin
               ld_cnt <= {(AW+1){1'b0}};
               blk_full <= 1'b1;
               loading <= ~m_trigger & len_act;
            end else begin
               ld_cnt <= next_ld_cnt;
            end
         end
      end
   end

   // ********************************************
   // Transform sequencing and block floating scaling
   // ********************************************
   reg busy;
   reg [2:0] pass_cnt;
   reg [3:0] shift_tot;
   reg ovf;
   wire [3:0] shift_lim = m_grow3 ? `FFTIO_MAX_SHIFT : `FFTIO_MAX_SHIFT_2BIT;
   wire [4:0] want = (i_pass_sign_bits > `FFTIO_MAX_PASS_SHIFT) ?
                     `FFTIO_MAX_PASS_SHIFT : i_pass_sign_bits;
   wire [4:0] room = {1'b0, shift_lim - shift_tot};
   wire [4:0] grant = (want > room) ? room : want;
   wire more_pass = (pass_cnt + 3'h1) < n_pass;

   always @(posedge i_clk_sys) begin
      if (ctl_rst) begin
         busy <= 1'b0;
         pass_cnt <= 3'h0;
         shift_tot <= 4'h0;
         ovf <= 1'b0;
         o_xform_start <= 1'b0;
         o_pass_shift <= 3'h0;
         o_shift_count <= 4'h0;
      end else begin
         o_xform_start <= 1'b0;
         if (blk_full & ~busy) begin
            busy <= 1'b1;
            pass_cnt <= 3'h0;
            shift_tot <= 4'h0;
            ovf <= 1'b0;
            o_pass_shift <= 3'h0;
            o_xform_start <= 1'b1;
         end else if (busy & i_pass_done) begin
            pass_cnt <= pass_cnt + 3'h1;
            // Three-place growth cannot overflow, so its flag is ignored
            if (i_pass_overflow & ~m_grow3) begin
               ovf <= 1'b1;
            end
            if (more_pass & ~dsb_sy[1]) begin
               o_pass_shift <= grant[2:0];
               shift_tot <= shift_tot + grant[3:0];
            end else begin
               o_pass_shift <= 3'h0;
            end
         end else if (busy & i_xform_done) begin
            busy <= 1'b0;
            o_shift_count <= ovf ? `FFTIO_OVF_CODE : shift_tot;
         end
      end
   end

   // ********************************************
   // Result dump
   // ********************************************
   reg ready;
   reg zero_out;
   reg [4:0] dly_cnt;
   reg [AW:0] dmp_cnt;
   reg [2:0] adv_pend;
   reg advance;
   // Tied strobes: each input edge yields 1, 2 or 4 dump advances
   wire [2:0] ratio_n = (m_ratio == 2'h0) ? 3'h1 : ((m_ratio == 2'h1) ? 3'h2 : 3'h4);
   wire out_ev = m_tied ? dis_rise : dos_rise;
   wire drive = ~o_result_valid_n & den_act;

   always @(posedge i_clk_sys) begin
      if (ctl_rst) begin
         adv_pend <= 3'h0;
         advance <= 1'b0;
      end else begin
         if (m_tied) begin
            advance <= adv_pend != 3'h0;
            if (out_ev) begin
               adv_pend <= ratio_n;
            end else if (adv_pend != 3'h0) begin
               adv_pend <= adv_pend - 3'h1;
            end
         end else begin
            advance <= out_ev;
            adv_pend <= 3'h0;
         end
      end
   end

   always @(posedge i_clk_sys) begin
      if (ctl_rst) begin
         ready <= 1'b0;
         zero_out <= 1'b0;
         dly_cnt <= 5'h00;
         dmp_cnt <= {(AW+1){1'b0}};
         o_result_valid_n <= 1'b1;
         o_res_addr <= {AW{1'b0}};
      end else begin
         if (busy & i_xform_done) begin
            ready <= 1'b1;
            zero_out <= ovf;
            dly_cnt <= 5'h00;
         end else if (ready & o_result_valid_n) begin
            if (~m_dav_dly | (dly_cnt == `FFTIO_DAV_DELAY)) begin
               o_result_valid_n <= 1'b0;
               dmp_cnt <= {(AW+1){1'b0}};
               o_res_addr <= {AW{1'b0}};
            end else if (advance) begin
               dly_cnt <= dly_cnt + 5'h01;
            end
         end else if (~o_result_valid_n) begin
            // Waits here until dump enable goes low
            if (drive & advance) begin
               if (dmp_cnt + {{AW{1'b0}}, 1'b1} == blk_len) begin
                  o_result_valid_n <= 1'b1;
                  ready <= 1'b0;
               end else begin
                  dmp_cnt <= dmp_cnt + {{AW{1'b0}}, 1'b1};
                  o_res_addr <= o_res_addr + {{(AW-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   end

   // Read data is one clock behind the address; strobes are far slower
   always @(posedge i_clk_sys) begin
      if (ctl_rst) begin
         o_real_result_out <= {DW{1'b0}};
         o_imag_result_out <= {DW{1'b0}};
         o_real_result_oe_n <= 1'b1;
         o_imag_result_oe_n <= 1'b1;
      end else begin
         o_real_result_out <= zero_out ? {DW{1'b0}} : i_res_real;
         o_imag_result_out <= zero_out ? {DW{1'b0}} : i_res_imag;
         o_real_result_oe_n <= ~drive;
         o_imag_result_oe_n <= ~drive;
      end
   end

endmodule

`default_nettype wire

// ===== verification/fftio_monitor.sv
// Concurrent checks on the FFT processor pin-level control block
`default_nettype none
module fftio_monitor (
   // Clock, reset and pins
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_config_strobe_n,
   input wire logic i_scaling_disable,
   input wire logic [15:0] i_aux_port,
   // Engine handshake
   input wire logic i_pass_done,
   input wire logic i_pass_overflow,
   input wire logic i_xform_done,
   input wire logic o_xform_start,
   input wire logic [2:0] o_pass_shift,
   // Outputs watched
   input wire logic [15:0] o_real_result_out,
   input wire logic o_real_result_oe_n,
   input wire logic o_imag_result_oe_n,
   input wire logic [3:0] o_shift_count,
   input wire logic o_load_flag,
   input wire logic o_result_valid_n,
   input wire logic o_smp_we,
   input wire logic [15:0] o_mode_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ovf_seen;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // Overflow of the running transform, forgotten when the next one starts
   always @(posedge i_clk_sys) begin
      if (i_rst || o_xform_start) begin
         ovf_seen <= 1'b0;
      end else if (i_pass_done && i_pass_overflow) begin
         ovf_seen <= 1'b1;
      end
   end
   sequence s_cfg_rise;
      !i_config_strobe_n ##1 i_config_strobe_n [*6];
   endsequence
   sequence s_cfg_held;
      !i_config_strobe_n [*6];
   endsequence
   a_mode_capture: assert property (s_cfg_rise |-> o_mode_word == $past(i_aux_port, 6))
      else $error("mode word differs from port at strobe rise");
   a_cfg_clears: assert property (s_cfg_held |-> o_result_valid_n && o_real_result_oe_n && !o_load_flag)
      else $error("control not held idle while config strobe low");
   a_oe_needs_valid: assert property (!o_real_result_oe_n |-> !$past(o_result_valid_n))
      else $error("real bus driven without valid results");
   a_imag_oe_valid: assert property (!o_imag_result_oe_n |-> !$past(o_result_valid_n))
      else $error("imag bus driven without valid results");
   a_pass_limit: assert property (o_pass_shift <= 3'h4)
      else $error("more than four shifts before a pass");
   a_scale_bypass: assert property (i_scaling_disable [*4] ##0 i_pass_done |-> ##2 o_pass_shift == 3'h0)
      else $error("shift applied with scaling disabled");
   a_ovf_code: assert property (i_xform_done && ovf_seen && !o_mode_word[1] |-> ##2 o_shift_count == 4'hF)
      else $error("overflow not reported as code fifteen");
   a_count_cap: assert property (i_xform_done && !ovf_seen && !o_mode_word[1] |-> ##2 o_shift_count != 4'hF)
      else $error("shift count reached fifteen without overflow");
   a_zero_on_ovf: assert property (o_shift_count == 4'hF && !o_mode_word[1] && !o_real_result_oe_n |-> o_real_result_out == 16'h0000)
      else $error("nonzero result after overflow");
   a_valid_prompt: assert property (i_xform_done && !o_mode_word[5] |-> ##[1:2] !o_result_valid_n)
      else $error("results valid late after transform done");
   a_we_single: assert property (o_smp_we |=> !o_smp_we)
      else $error("sample write longer than one cycle");
endmodule
bind fftio_top fftio_monitor u_fftio_monitor (.*);
`default_nettype wire

// ===== verification/fftio_partner.sv
// Sample source and result consumer facing the FFT processor pins
`default_nettype none
module fftio_partner (
   // Strobes and sample lines towards the device
   output logic o_input_strobe,
   output logic o_output_strobe,
   output logic [15:0] o_real_smp,
   output logic [15:0] o_imag_smp
);
   timeunit 1ns;
   timeprecision 1ns;
   // Strobes are active high, rest low between frames, 800 ns period
   // Edges sit 30 ns off the system clock so phase is not aligned to it
   task automatic send(input int n, input logic [15:0] base);
      for (int k = 0; k < n; k++) begin
         o_real_smp <= base + 16'(k);
         o_imag_smp <= ~(base + 16'(k));
         #230 o_input_strobe = 1'b1;
         #400 o_input_strobe = 1'b0;
         #170;
      end
      // Released lines must not keep showing the last sample
      o_real_smp <= ~o_real_smp;
      o_imag_smp <= ~o_imag_smp;
   endtask
   task automatic pull();
      #230 o_output_strobe = 1'b1;
      #400 o_output_strobe = 1'b0;
      #170;
   endtask
   initial begin
      o_input_strobe = 1'b0;
      o_output_strobe = 1'b0;
      o_real_smp = 16'h5A5A;
      o_imag_smp = 16'hA5A5;
   end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the FFT processor pin-level control block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys, i_rst, cfg_n, lden_n, dmp_n, sdis, pdone, povf, xdone, mode_sel;
   logic ist, ost, r_oe_n, i_oe_n, flag, val_n, we, xstart;
   logic [15:0] mode_val, p_real, p_imag, aux, r_out, i_out, s_real, s_imag, mode_w;
   logic [9:0] s_addr, res_addr;
   logic [4:0] signs;
   logic [3:0] scnt;
   logic [2:0] pshift;
   logic [15:0] got_r [0:15];
   logic [15:0] got_i [0:15];
   int mismatches, compares, we_cnt, xs_cnt;
   // Stand-in for the external buffer that isolates the mode word
   assign aux = mode_sel ? mode_val : p_imag;
   fftio_top u_fftio_top (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_real_sample_in(p_real), .i_aux_port(aux),
      .i_config_strobe_n(cfg_n), .i_load_enable_n(lden_n), .i_input_strobe(ist),
      .i_output_strobe(ost), .i_dump_enable_n(dmp_n), .i_scaling_disable(sdis),
      .o_real_result_out(r_out), .o_real_result_oe_n(r_oe_n), .o_imag_result_out(i_out),
      .o_imag_result_oe_n(i_oe_n), .o_shift_count(scnt), .o_load_flag(flag),
      .o_result_valid_n(val_n), .o_smp_real(s_real), .o_smp_imag(s_imag), .o_smp_addr(s_addr),
      .o_smp_we(we), .o_mode_word(mode_w), .o_xform_start(xstart), .o_pass_shift(pshift),
      .i_pass_done(pdone), .i_pass_sign_bits(signs), .i_pass_overflow(povf),
      .i_xform_done(xdone), .o_res_addr(res_addr), .i_res_real({6'h00, res_addr}),
      .i_res_imag(~{6'h00, res_addr}));
   fftio_partner u_fftio_partner (.o_input_strobe(ist), .o_output_strobe(ost),
      .o_real_smp(p_real), .o_imag_smp(p_imag));
   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      if (we) begin
         got_r[s_addr[3:0]] <= s_real;
         got_i[s_addr[3:0]] <= s_imag;
         we_cnt <= we_cnt + 1;
      end
      if (xstart) begin
         xs_cnt <= xs_cnt + 1;
      end
   end
   // ***************************************
   // Shared tasks
   // ***************************************
   task automatic clks(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ***************************************
   // Scenarios
   // ***************************************
   // Config low also clears the control logic, so it doubles as a reset
   task automatic t_config(input logic [15:0] m);
      mode_val <= m;
      mode_sel <= 1'b1;
      cfg_n <= 1'b0;
      clks(8);
      chk({15'h0, flag}, 16'h0000);
      chk({15'h0, val_n}, 16'h0001);
      cfg_n <= 1'b1;
      clks(6);
      mode_sel <= 1'b0;
      clks(2);
      chk(mode_w, m);
   endtask
   task automatic t_gate_load(input logic [15:0] base);
      we_cnt = 0;
      u_fftio_partner.send(2, base);
      clks(5);
      chk(16'(we_cnt), 16'h0000);
      lden_n <= 1'b0;
      clks(4);
      chk({15'h0, flag}, 16'h0001);
      u_fftio_partner.send(16, base);
      clks(1);
      lden_n <= 1'b1;
      clks(6);
      chk(16'(we_cnt), 16'h0010);
      for (int k = 0; k < 16; k++) begin
         chk(got_r[k], base + 16'(k));
         chk(got_i[k], ~(base + 16'(k)));
      end
   endtask
   task automatic t_trig_load();
      we_cnt = 0;
      u_fftio_partner.send(1, 16'h0100);
      clks(5);
      chk(16'(we_cnt), 16'h0000);
      lden_n <= 1'b0;
      clks(4);
      lden_n <= 1'b1;
      clks(2);
      chk({15'h0, flag}, 16'h0001);
      u_fftio_partner.send(4, 16'h0200);
      clks(4);
      chk({15'h0, flag}, 16'h0000);
      u_fftio_partner.send(12, 16'h0204);
      clks(6);
      chk(16'(we_cnt), 16'h0010);
   endtask
   // Two passes for a 16 point block; the last pass gets no shift
   task automatic t_engine(input logic ovf, input logic [2:0] sh1, input logic [3:0] cnt,
      input logic dly);
      chk(16'(xs_cnt), 16'h0001);
      xs_cnt = 0;
      signs <= 5'h07;
      pdone <= 1'b1;
      clks(1);
      pdone <= 1'b0;
      clks(3);
      chk({13'h0, pshift}, {13'h0, sh1});
      povf <= ovf;
      pdone <= 1'b1;
      clks(1);
      pdone <= 1'b0;
      povf <= 1'b0;
      clks(3);
      chk({13'h0, pshift}, 16'h0000);
      xdone <= 1'b1;
      clks(1);
      xdone <= 1'b0;
      clks(3);
      chk({12'h0, scnt}, {12'h0, cnt});
      chk({15'h0, val_n}, {15'h0, dly});
   endtask
   task automatic t_dump(input logic inc);
      if (dmp_n) begin
         u_fftio_partner.pull();
         clks(2);
         chk({15'h0, r_oe_n}, 16'h0001);
         dmp_n <= 1'b0;
      end
      clks(5);
      chk({15'h0, i_oe_n}, 16'h0000);
      for (int k = 0; k < 16; k++) begin
         chk(r_out, inc ? 16'(k) : 16'h0000);
         chk(i_out, inc ? ~16'(k) : 16'h0000);
         u_fftio_partner.pull();
         clks(1);
      end
      clks(4);
      chk({15'h0, val_n}, 16'h0001);
      chk({15'h0, r_oe_n}, 16'h0001);
   endtask
   // Tied strobes at ratio 4; valid waits for 24 internal advances
   task automatic t_tied_dump();
      u_fftio_partner.send(5, 16'h0300);
      clks(6);
      chk({15'h0, val_n}, 16'h0001);
      u_fftio_partner.send(1, 16'h0300);
      clks(6);
      chk({15'h0, val_n}, 16'h0000);
      chk({15'h0, i_oe_n}, 16'h0000);
      u_fftio_partner.send(3, 16'h0300);
      clks(6);
      chk({6'h00, res_addr}, 16'h000C);
      chk(r_out, 16'h0000);
      chk(i_out, 16'h0000);
      u_fftio_partner.send(1, 16'h0300);
      clks(6);
      chk({15'h0, val_n}, 16'h0001);
      chk({15'h0, r_oe_n}, 16'h0001);
   endtask
   initial begin
      i_rst = 1'b1;
      cfg_n = 1'b0;
      lden_n = 1'b1;
      dmp_n = 1'b1;
      sdis = 1'b0;
      pdone = 1'b0;
      povf = 1'b0;
      xdone = 1'b0;
      signs = 5'h00;
      mode_sel = 1'b1;
      mode_val = 16'h0000;
      mismatches = 0;
      compares = 0;
      we_cnt = 0;
      xs_cnt = 0;
      clks(6);
      i_rst <= 1'b0;
      clks(2);
      chk({15'h0, r_oe_n}, 16'h0001);
      chk(mode_w, 16'h0000);
      // Three-place growth: an overflow report from the engine is ignored
      t_config(16'h0003);
      t_gate_load(16'h1230);
      t_engine(1'b1, 3'h4, 4'h4, 1'b0);
      t_dump(1'b1);
      // Trigger load, quarter flag, delayed valid, tied strobes at ratio 4
      t_config(16'h0175);
      sdis <= 1'b1;
      t_trig_load();
      t_engine(1'b1, 3'h0, 4'hF, 1'b1);
      t_tied_dump();
      finish_test();
   end
   // Whole run needs well under 1 ms; a hang ends here
   initial begin
      #1000000;
      mismatches++;
      finish_test();
   end
endmodule
`default_nettype wire
